// ===== logic/dur_register_map.sv
// Purpose: register bank and host decode of a dual serial controller
// Assumes: host pins are asynchronous; strobes last at least four clk periods
// Notes: address and data must be stable around the strobe edge
`timescale 1ns/100ps
`include "dur_params.svh"
module dur_register_map (
   input wire logic clk,
   input wire logic rst,
   input wire logic chanASelectN,
   input wire logic chanBSelectN,
   input wire logic readN,
   input wire logic writeN,
   input wire logic [2:0] hostAddr,
   input wire logic [7:0] hostDataIn,
   output logic [7:0] hostDataOut,
   output logic hostDataOe,
   input wire logic [1:0] ctsN,
   input wire logic [1:0] dsrN,
   input wire logic [1:0] riN,
   input wire logic [1:0] cdN,
   output logic [1:0] dtrN,
   output logic [1:0] rtsN,
   output logic [1:0] userOutOneN,
   output logic [1:0] irqOutputGateN,
   input dur_pkg::dur_chan_stat_type [1:0] chanStat,
   output dur_pkg::dur_chan_ctrl_type [1:0] chanCtrl
);
   import dur_pkg::*;

   // ==========================================
   // pin synchroniser
   dur_host_bus_type hostRaw;
   dur_host_bus_type meta_q;
   dur_host_bus_type bus_q;

   assign hostRaw.selectN = {chanBSelectN, chanASelectN};
   assign hostRaw.readN = readN;
   assign hostRaw.writeN = writeN;
   assign hostRaw.addr = hostAddr;
   assign hostRaw.data = hostDataIn;

   // pins are not reset so the synchroniser keeps loading the ports under reset too
   always_ff @(posedge clk) begin
      meta_q <= hostRaw;
      bus_q <= meta_q;
   end

   // ==========================================
   // access sequencer
   dur_acc_state_type state_q;
   dur_acc_state_type state_d;
   logic [7:0] dataOut_q;
   logic [7:0] readVal [NUM_CHAN];

   wire anySel = ~(&bus_q.selectN);
   wire rdReq = anySel & ~bus_q.readN;
   wire wrReq = anySel & ~bus_q.writeN & bus_q.readN;
   wire idle = (state_q == ACC_IDLE);
   wire rdEvent = idle & rdReq;
   wire wrEvent = idle & wrReq;
   wire selA = ~bus_q.selectN[0];
   // channel a wins the data bus if both selects are low
   wire [7:0] readPick = selA ? readVal[0] : readVal[1];

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ACC_IDLE: begin
            if (rdReq) begin
               state_d = ACC_READ;
            end else if (wrReq) begin
               state_d = ACC_WRITE;
            end
         end
         ACC_READ: begin
            if (bus_q.readN) begin
               state_d = ACC_IDLE;
            end
         end
         ACC_WRITE: begin
            if (bus_q.writeN) begin
               state_d = ACC_IDLE;
            end
         end
         default: begin
            state_d = ACC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ACC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dataOut_q <= 8'h00;
      end else if (rdEvent) begin
         dataOut_q <= readPick;
      end
   end

   assign hostDataOut = dataOut_q;
   assign hostDataOe = (state_q == ACC_READ);

   // ==========================================
   // per channel register sets
   for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : gChan
      logic [3:0] ien_q;
      logic [7:0] lctl_q;
      logic [4:0] mctl_q;
      logic [7:0] divLow_q;
      logic [7:0] divHigh_q;
      logic [7:0] scr_q;
      logic [7:0] txd_q;
      logic txLoad_q;
      logic fifoEn_q;
      logic dma_q;
      logic [1:0] trig_q;
      logic rxRst_q;
      logic txRst_q;
      logic rxRead_q;
      logic intStatRd_q;
      logic lineStatRd_q;
      logic [3:0] mdmLevel;
      logic [3:0] mdmDelta;
      logic [3:0] mdmPinN;

      // own select and own copy of every register
      wire sel = ~bus_q.selectN[ch]; // see RULE_01
      wire wrHit = wrEvent & sel;
      wire rdHit = rdEvent & sel;
      // live register value, so a new divisor bit steers the next access
      wire divMode = lctl_q[`DUR_LCTL_DIV_BIT]; // see RULE_12
      wire [2:0] a = bus_q.addr;
      wire [7:0] d = bus_q.data;

      wire atData = (a == `DUR_OFF_DATA);
      wire atIen = (a == `DUR_OFF_IEN);
      wire atIstat = (a == `DUR_OFF_ISTAT);
      wire atLctl = (a == `DUR_OFF_LCTL);
      wire atMctl = (a == `DUR_OFF_MCTL);
      wire atLstat = (a == `DUR_OFF_LSTAT);
      wire atMstat = (a == `DUR_OFF_MSTAT);
      wire atScr = (a == `DUR_OFF_SCR);
      wire wrTx = wrHit & atData & ~divMode; // see RULE_02
      wire wrDivLow = wrHit & atData & divMode; // see RULE_03
      wire wrDivHigh = wrHit & atIen & divMode; // see RULE_03
      wire wrIen = wrHit & atIen & ~divMode; // see RULE_04
      wire wrFctl = wrHit & atIstat; // see RULE_06
      wire wrLctl = wrHit & atLctl; // see RULE_07
      wire wrMctl = wrHit & atMctl; // see RULE_08
      wire wrScr = wrHit & atScr; // see RULE_11
      wire rdRx = rdHit & atData & ~divMode; // see RULE_02
      wire rdIstat = rdHit & atIstat;
      wire rdLstat = rdHit & atLstat;
      wire rdMstat = rdHit & atMstat;
      // other fifo fields only take a write that also sets the enable
      wire fctlArm = d[`DUR_FCTL_EN_BIT];

      wire [7:0] valData = divMode ? divLow_q : chanStat[ch].rxData; // see RULE_03
      wire [7:0] valIen = divMode ? divHigh_q : {4'h0, ien_q}; // see RULE_04
      wire [7:0] valIstat = {fifoEn_q, fifoEn_q, 2'h0, chanStat[ch].intSource}; // see RULE_05
      wire [7:0] valMctl = {3'h0, mctl_q}; // see RULE_08
      wire [7:0] valMstat = {mdmLevel, mdmDelta}; // see RULE_10

      // line status is passed through; writes at five and six decode to nothing
      always_comb begin
         unique case (a)
            `DUR_OFF_DATA: readVal[ch] = valData;
            `DUR_OFF_IEN: readVal[ch] = valIen;
            `DUR_OFF_ISTAT: readVal[ch] = valIstat;
            `DUR_OFF_LCTL: readVal[ch] = lctl_q;
            `DUR_OFF_MCTL: readVal[ch] = valMctl;
            `DUR_OFF_LSTAT: readVal[ch] = chanStat[ch].lineStatus; // see RULE_09
            `DUR_OFF_MSTAT: readVal[ch] = valMstat;
            `DUR_OFF_SCR: readVal[ch] = scr_q;
         endcase
      end

      // transmit byte, kept apart from the received byte
      always_ff @(posedge clk) begin
         if (rst) begin
            txd_q <= `DUR_RST_TXD;
         end else if (wrTx) begin
            txd_q <= d; // see RULE_02
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            divLow_q <= `DUR_RST_DIV;
         end else if (wrDivLow) begin
            divLow_q <= d;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            divHigh_q <= `DUR_RST_DIV;
         end else if (wrDivHigh) begin
            divHigh_q <= d;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            ien_q <= `DUR_RST_IEN;
         end else if (wrIen) begin
            ien_q <= d[3:0];
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            lctl_q <= `DUR_RST_LCTL;
         end else if (wrLctl) begin
            lctl_q <= d;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            mctl_q <= `DUR_RST_MCTL;
         end else if (wrMctl) begin
            mctl_q <= d[4:0];
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            scr_q <= `DUR_RST_SCR;
         end else if (wrScr) begin
            scr_q <= d;
         end
      end

      // fifo control is write only; the enable is kept for the status read
      always_ff @(posedge clk) begin
         if (rst) begin
            fifoEn_q <= 1'b0;
         end else if (wrFctl) begin
            fifoEn_q <= fctlArm; // see RULE_06
         end
      end

      // dma and trigger keep their value on a write that clears the enable
      always_ff @(posedge clk) begin
         if (rst) begin
            dma_q <= 1'b0;
            trig_q <= 2'h0;
         end else if (wrFctl & fctlArm) begin
            dma_q <= d[`DUR_FCTL_DMA_BIT];
            trig_q <= d[`DUR_FCTL_TRIG_LSB +: 2];
         end
      end

      // one cycle strobes toward the serial core, one register each
      always_ff @(posedge clk) begin
         if (rst) begin
            txLoad_q <= 1'b0;
         end else begin
            txLoad_q <= wrTx;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            rxRst_q <= 1'b0;
         end else begin
            rxRst_q <= wrFctl & fctlArm & d[`DUR_FCTL_RXRST_BIT]; // see RULE_06
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            txRst_q <= 1'b0;
         end else begin
            txRst_q <= wrFctl & fctlArm & d[`DUR_FCTL_TXRST_BIT]; // see RULE_06
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            rxRead_q <= 1'b0;
         end else begin
            rxRead_q <= rdRx;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            intStatRd_q <= 1'b0;
         end else begin
            intStatRd_q <= rdIstat;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            lineStatRd_q <= 1'b0;
         end else begin
            lineStatRd_q <= rdLstat;
         end
      end

      // ==========================================
      // modem inputs, status bit order cts, dsr, ri, cd
      assign mdmPinN = {cdN[ch], riN[ch], dsrN[ch], ctsN[ch]};

      for (genvar i = 0; i < 4; i++) begin : gMdm
         dur_modem_delta uDelta (
            .clk(clk),
            .rst(rst),
            .pinN(mdmPinN[i]),
            .clearPulse(rdMstat),
            .level(mdmLevel[i]),
            .delta(mdmDelta[i])
         );
      end

      // ==========================================
      // outputs of this channel
      assign dtrN[ch] = ~mctl_q[`DUR_MCTL_DTR_BIT]; // see RULE_08
      assign rtsN[ch] = ~mctl_q[`DUR_MCTL_RTS_BIT];
      assign userOutOneN[ch] = ~mctl_q[`DUR_MCTL_USR_BIT];
      assign irqOutputGateN[ch] = ~mctl_q[`DUR_MCTL_IRQ_BIT];

      assign chanCtrl[ch].txData = txd_q;
      assign chanCtrl[ch].txLoad = txLoad_q;
      assign chanCtrl[ch].divisor = {divHigh_q, divLow_q};
      assign chanCtrl[ch].lineCtrl = lctl_q; // see RULE_07
      assign chanCtrl[ch].fifoEnable = fifoEn_q;
      assign chanCtrl[ch].rxFifoReset = rxRst_q;
      assign chanCtrl[ch].txFifoReset = txRst_q;
      assign chanCtrl[ch].dmaMode = dma_q;
      assign chanCtrl[ch].rxTrigger = trig_q;
      assign chanCtrl[ch].intEnable = ien_q;
      assign chanCtrl[ch].loopback = mctl_q[`DUR_MCTL_LOOP_BIT];
      assign chanCtrl[ch].irqEnable = mctl_q[`DUR_MCTL_IRQ_BIT];
      assign chanCtrl[ch].modemChange = |mdmDelta;
      assign chanCtrl[ch].rxRead = rxRead_q;
      assign chanCtrl[ch].intStatRead = intStatRd_q;
      assign chanCtrl[ch].lineStatRead = lineStatRd_q;
   end
endmodule

// ===== logic/dur_params.svh
// Purpose: offsets, field positions and reset values of the dual channel register bank
// Assumes: one clock domain, host bus pins synchronised inside the bank
// Notes: one copy of every register per channel
// How it works
// RULE_01: each of the two channels has its own full register set, picked by its own select.
// RULE_02: offset zero with the divisor bit clear reads received data and writes transmit data.
// RULE_03: with the divisor bit set, offsets zero and one reach the low and high divisor bytes.
// RULE_04: offset one with the divisor bit clear is the four bit interrupt enable register.
// RULE_05: a read of offset two gives the fifo enable pair, two zeros and the source code.
// RULE_06: a write of offset two loads fifo enable, and the two fifo resets, dma mode and trigger only when it sets the enable.
// RULE_07: offset three is the line control register whose top bit is the divisor bit.
// RULE_08: offset four is the modem control register with five live bits and three zeros.
// RULE_09: offset five reads line status and drops writes.
// RULE_10: offset six reads modem change flags low and modem input states high, drops writes.
// RULE_11: offset seven is a scratch byte that affects nothing else.
// RULE_12: a new divisor bit value already steers the very next host access.
`ifndef DUR_PARAMS_SVH
`define DUR_PARAMS_SVH
`define DUR_OFF_DATA 3'h0
`define DUR_OFF_IEN 3'h1
`define DUR_OFF_ISTAT 3'h2
`define DUR_OFF_LCTL 3'h3
`define DUR_OFF_MCTL 3'h4
`define DUR_OFF_LSTAT 3'h5
`define DUR_OFF_MSTAT 3'h6
`define DUR_OFF_SCR 3'h7
`define DUR_LCTL_DIV_BIT 7
`define DUR_FCTL_EN_BIT 0
`define DUR_FCTL_RXRST_BIT 1
`define DUR_FCTL_TXRST_BIT 2
`define DUR_FCTL_DMA_BIT 3
`define DUR_FCTL_TRIG_LSB 6
`define DUR_MCTL_DTR_BIT 0
`define DUR_MCTL_RTS_BIT 1
`define DUR_MCTL_USR_BIT 2
`define DUR_MCTL_IRQ_BIT 3
`define DUR_MCTL_LOOP_BIT 4
`define DUR_RST_IEN 4'h0
`define DUR_RST_LCTL 8'h00
`define DUR_RST_MCTL 5'h00
`define DUR_RST_DIV 8'h00
`define DUR_RST_SCR 8'h00
`define DUR_RST_TXD 8'h00
`endif

// ===== logic/dur_pkg.sv
// Purpose: shared types of the dual channel register bank
// Assumes: constants live in dur_params.svh
// Notes: structs carry the per channel link to the serial core
package dur_pkg;
   localparam int NUM_CHAN = 2;
   // ==========================================
   // host pins after synchronisation
   typedef struct packed {
      logic [1:0] selectN;
      logic readN;
      logic writeN;
      logic [2:0] addr;
      logic [7:0] data;
   } dur_host_bus_type;
   // ==========================================
   // bank to serial core
   typedef struct packed {
      logic [7:0] txData;
      logic txLoad;
      logic [15:0] divisor;
      logic [7:0] lineCtrl;
      logic fifoEnable;
      logic rxFifoReset;
      logic txFifoReset;
      logic dmaMode;
      logic [1:0] rxTrigger;
      logic [3:0] intEnable;
      logic loopback;
      logic irqEnable;
      logic modemChange;
      logic rxRead;
      logic intStatRead;
      logic lineStatRead;
   } dur_chan_ctrl_type;
   // ==========================================
   // serial core to bank
   typedef struct packed {
      logic [7:0] rxData;
      logic [7:0] lineStatus;
      logic [3:0] intSource;
   } dur_chan_stat_type;
   typedef enum logic [1:0] {
      ACC_IDLE = 2'h0,
      ACC_READ = 2'h1,
      ACC_WRITE = 2'h2
   } dur_acc_state_type;
endpackage

// ===== logic/dur_modem_delta.sv
// Purpose: one modem input, synchronised, with a sticky change flag
// Assumes: pin is active low and asynchronous to clk
// Notes: a pin already low when reset ends is not flagged
`timescale 1ns/100ps
module dur_modem_delta (
   input wire logic clk,
   input wire logic rst,
   input wire logic pinN,
   input wire logic clearPulse,
   output logic level,
   output logic delta
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic primed_q;
   logic delta_q;
   wire changed = primed_q & (sync_q != prev_q);
   // ==========================================
   // synchroniser
   always_ff @(posedge clk) begin
      meta_q <= pinN;
      sync_q <= meta_q;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_q <= 1'b1;
         primed_q <= 1'b0;
      end else begin
         prev_q <= sync_q;
         primed_q <= 1'b1;
      end
   end
   // ==========================================
   // sticky flag, a change in the clearing cycle survives
   always_ff @(posedge clk) begin
      if (rst) begin
         delta_q <= 1'b0;
      end else if (changed) begin
         delta_q <= 1'b1; // see RULE_10
      end else if (clearPulse) begin
         delta_q <= 1'b0;
      end
   end
   assign level = ~prev_q;
   assign delta = delta_q;
endmodule

// ===== verification/dur_register_map_assertions.sv
// Purpose: port level checks of the dual channel register bank
// Assumes: host strobes stay low six clk and high four clk
// Notes: pulses and register changes are traced back two clk to the pins
`timescale 1ns/100ps
module dur_register_map_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic chanASelectN,
   input wire logic chanBSelectN,
   input wire logic readN,
   input wire logic writeN,
   input wire logic [2:0] hostAddr,
   input wire logic [7:0] hostDataOut,
   input wire logic hostDataOe,
   input wire logic [1:0] irqOutputGateN,
   input dur_pkg::dur_chan_ctrl_type [1:0] chanCtrl
);
   import dur_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ==========
   // host side
   oe_cause_a: assert property (
      $rose(hostDataOe) |-> !$past(readN, 2) && !($past(chanASelectN, 2) && $past(chanBSelectN, 2)))
      else $error("output enable without a selected read");
   oe_release_a: assert property (
      readN && hostDataOe |-> ##[1:4] !hostDataOe)
      else $error("output enable outlives the read strobe");
   data_hold_a: assert property (
      hostDataOe && $past(hostDataOe) |-> $stable(hostDataOut))
      else $error("read data moved while driven");
   // ==========
   // core side
   tx_load_a: assert property (
      chanCtrl[0].txLoad |-> !$past(writeN, 2) && !$past(chanASelectN, 2)
      && $past(hostAddr, 2) == 3'h0 && !chanCtrl[0].lineCtrl[7])
      else $error("transmit load without a data write");
   tx_pulse_a: assert property (
      chanCtrl[0].txLoad |=> !chanCtrl[0].txLoad)
      else $error("transmit load longer than one clk");
   rx_read_a: assert property (
      chanCtrl[0].rxRead |-> !$past(readN, 2) && $past(hostAddr, 2) == 3'h0
      && !chanCtrl[0].lineCtrl[7])
      else $error("receive read pulse without a data read");
   div_write_a: assert property (
      $changed(chanCtrl[1].divisor) |-> !$past(writeN, 2) && !$past(chanBSelectN, 2)
      && chanCtrl[1].lineCtrl[7] && $past(hostAddr, 2) <= 3'h1)
      else $error("divisor changed without a divisor write");
   ien_write_a: assert property (
      $changed(chanCtrl[0].intEnable) |-> !$past(writeN, 2) && $past(hostAddr, 2) == 3'h1
      && !chanCtrl[0].lineCtrl[7])
      else $error("interrupt enable changed without its write");
   int_stat_read_a: assert property (
      chanCtrl[0].intStatRead |-> !$past(readN, 2) && $past(hostAddr, 2) == 3'h2)
      else $error("status read pulse at wrong offset");
   fifo_reset_a: assert property (
      chanCtrl[1].rxFifoReset || chanCtrl[1].txFifoReset |-> chanCtrl[1].fifoEnable)
      else $error("fifo reset while fifos disabled");
   lctl_write_a: assert property (
      $changed(chanCtrl[0].lineCtrl) |-> !$past(writeN, 2) && $past(hostAddr, 2) == 3'h3)
      else $error("line control changed without its write");
   irq_gate_a: assert property (
      irqOutputGateN[1] == !chanCtrl[1].irqEnable)
      else $error("irq gate pin disagrees with modem control");
   line_stat_read_a: assert property (
      chanCtrl[1].lineStatRead |-> !$past(readN, 2) && $past(hostAddr, 2) == 3'h5)
      else $error("line status pulse at wrong offset");
endmodule
bind dur_register_map dur_register_map_assertions u_chk (.clk, .rst, .chanASelectN,
   .chanBSelectN, .readN, .writeN, .hostAddr, .hostDataOut, .hostDataOe, .irqOutputGateN,
   .chanCtrl);

// ===== verification/dur_host_model.sv
// Purpose: host processor bus master for the register bank
// Assumes: strobes low six clk, high four clk, well inside the bank's needs
// Notes: idle data lines show the inverse of the last byte, never a stale copy
`timescale 1ns/100ps
module dur_host_model (
   input wire logic clk,
   input wire logic [7:0] hostDataOut,
   input wire logic hostDataOe,
   output logic chanASelectN,
   output logic chanBSelectN,
   output logic readN,
   output logic writeN,
   output logic [2:0] hostAddr,
   output logic [7:0] hostDataIn
);
   logic hung = 1'b0;
   initial begin
      {chanBSelectN, chanASelectN, readN, writeN} = 4'hF;
      hostAddr = 3'h0;
      hostDataIn = 8'hFF;
   end
   // ==========
   // one access per strobe, selects A and B each their own copy
   task automatic access(input logic [1:0] selN, input logic wr, input logic [2:0] a,
         input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      #1;
      {chanBSelectN, chanASelectN} = selN;
      hostAddr = a;
      hostDataIn = wr ? d : ~hostDataIn;
      writeN = !wr;
      readN = wr;
      repeat (6) @(posedge clk);
      q = hostDataOut;
      if (!wr && hostDataOe !== 1'b1) hung = 1'b1;
      #1;
      {chanBSelectN, chanASelectN, readN, writeN} = 4'hF;
      hostDataIn = ~hostDataIn;
      repeat (4) @(posedge clk);
   endtask
endmodule

// ===== verification/dur_register_map_test.sv
// Purpose: self-checking bench of the dual channel register bank
// Assumes: host model owns bus pins, bench owns status and modem inputs
// Notes: modem change flags are tracked per channel and cleared by a status read
`timescale 1ns/100ps
module dur_register_map_test;
   import dur_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic chanASelectN, chanBSelectN, readN, writeN, hostDataOe, wr;
   logic [2:0] hostAddr, a;
   logic [7:0] hostDataIn, hostDataOut, q, d;
   logic [1:0] ctsN = 2'h3, dsrN = 2'h3, riN = 2'h3, cdN = 2'h3;
   logic [1:0] dtrN, rtsN, userOutOneN, irqOutputGateN, selN;
   dur_chan_stat_type [1:0] chanStat = '0;
   dur_chan_ctrl_type [1:0] chanCtrl;
   logic [7:0] lineCtl[2], divLo[2], divHi[2], scr[2];
   logic [3:0] intEn[2], dlt[2];
   logic [4:0] mdmCtl[2];
   logic fen[2], dma[2];
   logic [1:0] trig[2];
   logic [31:0] seed = 32'h0541F897;
   logic [31:0] r;
   int errTotal = 0;
   int cmpCount = 0;
   int c;
   always #10 clk = ~clk;
   dur_register_map DUT (.clk, .rst, .chanASelectN, .chanBSelectN, .readN, .writeN,
      .hostAddr, .hostDataIn, .hostDataOut, .hostDataOe, .ctsN, .dsrN, .riN, .cdN,
      .dtrN, .rtsN, .userOutOneN, .irqOutputGateN, .chanStat, .chanCtrl);
   dur_host_model host (.clk, .hostDataOut, .hostDataOe, .chanASelectN, .chanBSelectN,
      .readN, .writeN, .hostAddr, .hostDataIn);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errTotal++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ==========
   // reference model
   function automatic logic [7:0] exp_rd(int k, logic [2:0] o);
      case (o)
         3'h0: return lineCtl[k][7] ? divLo[k] : chanStat[k].rxData;
         3'h1: return lineCtl[k][7] ? divHi[k] : {4'h0, intEn[k]};
         3'h2: return {fen[k], fen[k], 2'h0, chanStat[k].intSource};
         3'h3: return lineCtl[k];
         3'h4: return {3'h0, mdmCtl[k]};
         3'h5: return chanStat[k].lineStatus;
         3'h6: return {~cdN[k], ~riN[k], ~dsrN[k], ~ctsN[k], dlt[k]};
         default: return scr[k];
      endcase
   endfunction
   task automatic mdl_wr(int k, logic [2:0] o, logic [7:0] v);
      case (o)
         3'h0: if (lineCtl[k][7]) divLo[k] = v;
         3'h1: if (lineCtl[k][7]) divHi[k] = v; else intEn[k] = v[3:0];
         3'h2: begin
            fen[k] = v[0];
            if (v[0]) {trig[k], dma[k]} = {v[7:6], v[3]};
         end
         3'h3: lineCtl[k] = v;
         3'h4: mdmCtl[k] = v[4:0];
         3'h7: scr[k] = v;
         default: ;
      endcase
   endtask
   task automatic chk_ports(int k);
      chk(chanCtrl[k].divisor, {divHi[k], divLo[k]});
      chk({chanCtrl[k].lineCtrl, chanCtrl[k].intEnable, 4'h0}, {lineCtl[k], intEn[k], 4'h0});
      chk({11'h0, chanCtrl[k].fifoEnable, chanCtrl[k].dmaMode, chanCtrl[k].rxTrigger,
         chanCtrl[k].loopback}, {11'h0, fen[k], dma[k], trig[k], mdmCtl[k][4]});
      chk({12'h0, dtrN[k], rtsN[k], userOutOneN[k], irqOutputGateN[k]},
         {12'h0, ~mdmCtl[k][0], ~mdmCtl[k][1], ~mdmCtl[k][2], ~mdmCtl[k][3]});
      chk({15'h0, chanCtrl[k].modemChange}, {15'h0, |dlt[k]});
   endtask
   task automatic giveVerdict();
      if (errTotal == 0 && cmpCount > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ==========
   // stimulus: reset values first, then random traffic
   initial begin
      lineCtl = '{default: 8'h00};
      divLo = '{default: 8'h00};
      divHi = '{default: 8'h00};
      scr = '{default: 8'h00};
      intEn = '{default: 4'h0};
      dlt = '{default: 4'h0};
      mdmCtl = '{default: 5'h00};
      fen = '{default: 1'b0};
      dma = '{default: 1'b0};
      trig = '{default: 2'h0};
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      for (int i = 0; i < 200; i++) begin
         @(posedge clk);
         #1;
         r = rnd();
         chanStat[r[0]] = dur_chan_stat_type'(r[31:12]);
         if (r[11:9] == 3'h0) begin
            for (int k = 0; k < 2; k++) begin
               dlt[k] |= {cdN[k] ^ r[24 + k], riN[k] ^ r[26 + k],
                  dsrN[k] ^ r[28 + k], ctsN[k] ^ r[30 + k]};
            end
            {ctsN, dsrN, riN, cdN} = r[31:24];
            repeat (4) @(posedge clk);
         end
         selN = (r[7:6] == 2'h1) ? 2'h1 : (r[7:6] == 2'h2) ? 2'h0 : 2'h2;
         wr = r[8] && i >= 16;
         a = (i < 16) ? i[2:0] : r[5:3];
         if (i < 16) selN = i[3] ? 2'h1 : 2'h2;
         d = r[23:16];
         host.access(selN, wr, a, d, q);
         if (!wr) begin
            c = selN[0] ? 1 : 0;
            chk({8'h0, q}, {8'h0, exp_rd(c, a)});
            for (int k = 0; k < 2; k++) begin
               if (!selN[k] && a == 3'h6) dlt[k] = 4'h0;
            end
         end else begin
            for (int k = 0; k < 2; k++) begin
               if (!selN[k]) begin
                  if (a == 3'h0 && !lineCtl[k][7]) chk({8'h0, chanCtrl[k].txData}, {8'h0, d});
                  mdl_wr(k, a, d);
                  chk_ports(k);
               end
            end
         end
      end
      chk({15'h0, host.hung}, 16'h0);
      giveVerdict();
   end
   initial begin
      #400000;
      errTotal++;
      giveVerdict();
   end
endmodule
